// file: shared/tcr_pkg.sv
package tcr_pkg;
   localparam int unsigned coord_w = 10;
   localparam logic [9:0] coord_max = 10'h3ff;
   localparam logic [7:0] hdr_touched = 8'h11;
   localparam logic [7:0] hdr_released = 8'h10;
   localparam logic [2:0] idx_hdr = 3'h0;
   localparam logic [2:0] idx_x_hi = 3'h1;
   localparam logic [2:0] idx_x_lo = 3'h2;
   localparam logic [2:0] idx_y_hi = 3'h3;
   localparam logic [2:0] idx_y_lo = 3'h4;
   localparam logic [2:0] idx_last = 3'h4;

   typedef struct packed {
      logic [9:0] x;
      logic [9:0] y;
   } tcr_coord_t;

   typedef enum logic [2:0] {
      tcr_idle = 3'b001,
      tcr_press = 3'b010,
      tcr_release = 3'b100
   } tcr_state_t;
endpackage

// file: src/tcr_byte_sel.sv
module tcr_byte_sel (
   input wire logic [2:0] idx,
   input wire tcr_pkg::tcr_coord_t coord,
   output logic [7:0] byte_out
);
   logic [15:0] x_word;
   logic [15:0] y_word;
   assign x_word = {6'h00, coord.x};
   assign y_word = {6'h00, coord.y};
   // upper byte first on each axis, x before y
   assign byte_out = (idx == tcr_pkg::idx_x_hi) ? x_word[15:8] :
                     (idx == tcr_pkg::idx_x_lo) ? x_word[7:0] :
                     (idx == tcr_pkg::idx_y_hi) ? y_word[15:8] :
                     (idx == tcr_pkg::idx_y_lo) ? y_word[7:0] :
                     tcr_pkg::hdr_touched;
endmodule

// file: src/tcr_reporter.sv
// Operation
// - 1024 steps per axis, panel resolution
// - origin upper left, growing right, down
// - reports are raw binary bytes
// - pressed report starts with header 11h
// - x follows in two bytes, 0..3ffh
// - y follows x, two bytes, 0..3ffh
// - high byte first; header, x, y
// - repeat pressed reports while touched
// - on lift send single 10h byte
module tcr_reporter #(
   // two stages at least; the last two must agree before a change counts
   parameter int unsigned n_sync = 3
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic touch_in,
   input wire logic sample_valid,
   input wire tcr_pkg::tcr_coord_t sample,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic report_busy
);
   logic sync_r[n_sync];
   logic sync_settled;
   logic sync_level;
   logic touch_r;

   tcr_pkg::tcr_state_t state_r;
   tcr_pkg::tcr_state_t state_nxt;
   logic [2:0] idx_r;
   logic [2:0] idx_nxt;
   tcr_pkg::tcr_coord_t pos_r;
   tcr_pkg::tcr_coord_t frame_r;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   logic [7:0] sel_byte;
   logic [2:0] sel_idx;
   logic accept;
   logic at_last;
   logic frame_load;
   logic have_pos_r;
   logic is_idle;
   logic is_press;
   logic start_report;
   logic end_report;
   logic lift_seen;
   logic to_release;
   tcr_pkg::tcr_coord_t frame_src;

   // only the first stage samples the pin
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_r[0] <= 1'b0;
      end else begin
         sync_r[0] <= touch_in;
      end
   end

   // later stages never see the pin, only the stage before
   for (genvar gi = 1; gi < n_sync; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            sync_r[gi] <= 1'b0;
         end else begin
            sync_r[gi] <= sync_r[gi - 1];
         end
      end
   end

   // a change counts once the last two stages agree, so a lone glitch is dropped
   assign sync_settled = (sync_r[n_sync - 2] == sync_r[n_sync - 1]);
   assign sync_level = sync_r[n_sync - 1];

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         touch_r <= 1'b0;
      end else if (sync_settled) begin
         touch_r <= sync_level;
      end
   end

   // sample is already clamped by its width to 0..3ffh, origin upper left
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pos_r <= '0;
      end else if (sample_valid) begin
         pos_r <= sample;
      end
   end

   // stays set until reset; a touch before any reading has no coordinates to send
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         have_pos_r <= 1'b0;
      end else if (sample_valid) begin
         have_pos_r <= 1'b1;
      end
   end

   // state decode shared by the frame load and the outputs
   assign is_idle = (state_r == tcr_pkg::tcr_idle);
   assign is_press = (state_r == tcr_pkg::tcr_press);
   // a byte moves only on an edge where both sides agree
   assign accept = tx_valid & tx_ready;
   assign at_last = (idx_r == tcr_pkg::idx_last);
   assign end_report = accept & at_last;
   assign start_report = touch_r & have_pos_r;
   assign lift_seen = ~touch_r;
   // coordinates frozen per report so x and y belong to one reading
   assign frame_load = (state_nxt == tcr_pkg::tcr_press) & (idx_nxt == tcr_pkg::idx_hdr) &
                       (~is_press | accept);

   // state walk; touch is looked at only on report boundaries
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         tcr_pkg::tcr_idle: begin
            // a new report only when a contact and a position exist
            if (start_report) begin
               state_nxt = tcr_pkg::tcr_press;
            end
         end
         tcr_pkg::tcr_press: begin
            // lift seen only at a report boundary, never mid report
            if (end_report && lift_seen) begin
               state_nxt = tcr_pkg::tcr_release;
            end
         end
         tcr_pkg::tcr_release: begin
            // one release byte, then silence
            if (accept) begin
               state_nxt = tcr_pkg::tcr_idle;
            end
         end
         default: begin
            state_nxt = tcr_pkg::tcr_idle;
         end
      endcase
   end

   // byte index inside a pressed report; wraps to the header after the last byte
   always_comb begin
      idx_nxt = idx_r;
      case (state_r)
         tcr_pkg::tcr_idle: begin
            idx_nxt = tcr_pkg::idx_hdr;
         end
         tcr_pkg::tcr_press: begin
            if (end_report) begin
               idx_nxt = tcr_pkg::idx_hdr;
            end else if (accept) begin
               idx_nxt = 3'(idx_r + 3'h1);
            end
         end
         tcr_pkg::tcr_release: begin
            idx_nxt = tcr_pkg::idx_hdr;
         end
         default: begin
            idx_nxt = tcr_pkg::idx_hdr;
         end
      endcase
   end

   // next index drives the selector so the byte flop loads in step
   assign sel_idx = idx_nxt;
   // the fresh reading is routed straight through on the edge that loads it
   assign frame_src = frame_load ? pos_r : frame_r;

   tcr_byte_sel u_sel (
      .idx(sel_idx),
      .coord(frame_src),
      .byte_out(sel_byte)
   );

   // raw binary bytes, release header carries no coordinates
   assign to_release = (state_nxt == tcr_pkg::tcr_release);
   assign data_nxt = to_release ? tcr_pkg::hdr_released : sel_byte;

   // registers kept apart so each reset value is plain to see
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_r <= tcr_pkg::tcr_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   // index and state advance on the same edge so no byte is skipped
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         idx_r <= tcr_pkg::idx_hdr;
      end else begin
         idx_r <= idx_nxt;
      end
   end

   // output byte from a flop loaded every edge; it holds while the host stalls because data_nxt repeats
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         data_r <= 8'h00;
      end else begin
         data_r <= data_nxt;
      end
   end

   // frozen copy so x and y of one report come from one reading
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         frame_r <= '0;
      end else if (frame_load) begin
         frame_r <= pos_r;
      end
   end

   // back to back reports while held
   assign tx_data = data_r;
   assign tx_valid = ~is_idle;
   // busy mirrors valid for hosts that watch only one line
   assign report_busy = tx_valid;
endmodule

// file: verif/tcr_host.sv
module tcr_host (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic slow,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   // a slow host stalls every other cycle
   always @(posedge ref_clk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      tx_ready <= srst ? 1'b0 : (slow ? ~tx_ready : 1'b1);
   end
endmodule

// file: verif/tcr_reporter_asserts.sv
module tcr_chk (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic report_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [2:0] n_r;
   wire take = tx_valid && tx_ready;
   wire rel = n_r == 3'h0 && tx_data == 8'h10;
   // byte index inside the report being offered
   always_ff @(posedge ref_clk)
      n_r <= (srst || (take && (rel || n_r == 3'h4))) ? 3'h0 : n_r + 3'(take);
   a_reset_quiet: assert property (disable iff (1'b0) srst |=> !tx_valid && tx_data == 8'h00)
      else $error("output active after reset");
   a_hdr_code: assert property (tx_valid && n_r == 3'h0 |-> tx_data inside {8'h11, 8'h10})
      else $error("bad header byte");
   a_hi_range: assert property (tx_valid && n_r inside {3'h1, 3'h3} |-> tx_data[7:2] == 6'h00)
      else $error("coordinate above 3ff");
   a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("byte dropped while stalled");
   a_busy_mirror: assert property (report_busy == tx_valid)
      else $error("busy differs from valid");
   a_release_end: assert property (take && rel |=> !tx_valid)
      else $error("output after release byte");
   a_next_byte: assert property (take && !rel |=> tx_valid)
      else $error("gap inside report stream");
   a_idle_start: assert property (!tx_valid |=> !tx_valid || tx_data == 8'h11)
      else $error("report starts without header");
endmodule
bind tcr_reporter tcr_chk i_tcr_chk (.ref_clk(ref_clk), .srst(srst), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .report_busy(report_busy));

// file: verif/tcr_reporter_bench.sv
module tcr_reporter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, srst, touch_in, sample_valid, tx_valid, tx_ready, report_busy, slow;
   logic [7:0] tx_data;
   tcr_pkg::tcr_coord_t sample;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   tcr_reporter i_tcr_reporter (.ref_clk(ref_clk), .srst(srst), .touch_in(touch_in), .sample_valid(sample_valid),
      .sample(sample), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .report_busy(report_busy));
   tcr_host i_tcr_host (.ref_clk(ref_clk), .srst(srst), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task close_out;
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end
   task chk(string what, logic [7:0] exp, logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wait_bytes(int n);
      int k;
      k = 0;
      while (i_tcr_host.got.size() < n && k < 400) begin
         @(posedge ref_clk);
         k++;
      end
   endtask
   // touch at c, move to c2 once the first report is out, lift after four reports have begun;
   // reports one and two carry c, every later one carries c2
   task run(tcr_pkg::tcr_coord_t c, tcr_pkg::tcr_coord_t c2, logic s);
      logic [7:0] e[5];
      logic [7:0] e2[5];
      int k;
      e = '{8'h11, {6'h00, c.x[9:8]}, c.x[7:0], {6'h00, c.y[9:8]}, c.y[7:0]};
      e2 = '{8'h11, {6'h00, c2.x[9:8]}, c2.x[7:0], {6'h00, c2.y[9:8]}, c2.y[7:0]};
      i_tcr_host.got.delete();
      slow <= s;
      sample <= c;
      sample_valid <= 1'b1;
      touch_in <= 1'b1;
      wait_bytes(5);
      sample <= c2;
      wait_bytes(17);
      touch_in <= 1'b0;
      repeat (60) @(posedge ref_clk);
      chk("count", 8'h01, 8'(i_tcr_host.got.size() % 5));
      for (k = 0; k < i_tcr_host.got.size() - 1; k++) begin
         chk("byte", (k < 10) ? e[k % 5] : e2[k % 5], i_tcr_host.got[k]);
      end
      chk("last", 8'h10, i_tcr_host.got[$]);
   endtask
   task t_example;
      run('{x: 10'h017, y: 10'h1f4}, '{x: 10'h017, y: 10'h1f4}, 1'b0);
   endtask
   task t_corner;
      run('{x: 10'h3ff, y: 10'h000}, '{x: 10'h3ff, y: 10'h000}, 1'b1);
   endtask
   task t_move;
      run('{x: 10'h017, y: 10'h1f4}, '{x: 10'h000, y: 10'h3ff}, 1'b1);
   endtask
   // reset in mid run clears the stored reading; a touch without one stays silent
   task t_no_sample;
      i_tcr_host.got.delete();
      srst <= 1'b1;
      sample_valid <= 1'b0;
      touch_in <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (30) @(posedge ref_clk);
      chk("silent", 8'h00, 8'(i_tcr_host.got.size()));
      touch_in <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask
   initial begin
      srst = 1'b1;
      touch_in = 1'b0;
      sample_valid = 1'b0;
      sample = '0;
      slow = 1'b0;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      t_example();
      t_corner();
      t_no_sample();
      t_move();
      close_out();
   end
endmodule
